/* rtl/rft_pkg.sv */
package rft_pkg;
  // frame type codes, carried in byte 0 of the first payload word
  localparam logic [7:0] TYPE_H2D = 8'h27;
  localparam logic [7:0] TYPE_D2H = 8'h34;
  localparam logic [2:0] FRAME_WORDS = 3'h5;
  localparam logic [2:0] LAST_WORD   = 3'h4;
  // apb register byte offsets
  localparam logic [7:0] OFS_FEAT    = 8'h00;
  localparam logic [7:0] OFS_COUNT   = 8'h04;
  localparam logic [7:0] OFS_LBA_LO  = 8'h08;
  localparam logic [7:0] OFS_LBA_HI  = 8'h0C;
  localparam logic [7:0] OFS_DEVICE  = 8'h10;
  localparam logic [7:0] OFS_CMD     = 8'h14;
  localparam logic [7:0] OFS_CTRL    = 8'h18;
  localparam logic [7:0] OFS_AUX     = 8'h1C;
  localparam logic [7:0] OFS_TLIM    = 8'h20;
  localparam logic [7:0] OFS_PORT    = 8'h24;
  localparam logic [7:0] OFS_STATUS  = 8'h28;
  localparam logic [7:0] OFS_ERROR   = 8'h2C;
  localparam logic [7:0] OFS_XFER    = 8'h30;
  // field positions
  localparam int BIT_BUSY   = 7;
  localparam int BIT_DATA_REQ = 3;
  localparam int BIT_SOFT_RST = 2;
  localparam int BIT_CUPD   = 15;
  localparam int BIT_TLIM_EN  = 8;
  localparam int BIT_D2H_I  = 14;
  // command that may pass while busy
  localparam logic [7:0] CMD_DEV_RESET = 8'h08;
  // reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  // busy deadline: 400 ns at 50 ns per cycle, rounded down
  localparam int BUSY_LIMIT_NS = 400;
  localparam int CLK_PERIOD_NS = 50;
  localparam int BUSY_LIMIT_CYC = BUSY_LIMIT_NS / CLK_PERIOD_NS;

  // shadow register block
  typedef struct packed {
    logic [15:0] features;
    logic [15:0] count;
    logic [47:0] lba;
    logic [7:0]  device;
    logic [7:0]  command;
    logic [7:0]  control;
    logic [7:0]  status;
    logic [7:0]  error;
  } rft_shadow_t;

  // one word on the link stream
  typedef struct packed {
    logic        valid;
    logic        last;
    logic [31:0] data;
  } rft_word_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b10
  } rft_state_t;
endpackage

/* rtl/rft_register_fis_transport.sv */
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
// Function
// - host-to-device frame uses type 27h and is five words long
// - type code sits in byte 0 of the first word
// - fifth word carries the 32-bit auxiliary parameter
// - command-update bit is one for command writes, zero for control writes
// - never send command-update together with soft reset
// - all reserved bits are sent as zero
// - reserved fields of received frames are ignored
// - multiplier port field holds the destination port address
// - shadow registers are copied into their fixed byte positions
// - time-limit byte sent only when enabled, otherwise zero
// - frame on every accepted command write; control write only when value changes; code launches neither unless the sequencer is idle
// - busy set within 400 ns of a command write; code sets it a cycle later, but not for a write during a frame in flight
// - busy set on soft reset rising edge; other control writes leave it
// - busy not raised for control writes without soft reset rising
// - command writes ignored while busy or data-request, except device reset
// - device-to-host frame type 34h, five words, reserved upper bytes
// - valid received frame is copied into the shadow block
// - frame arriving with busy and data-request clear is discarded
module rft_register_fis_transport (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // transmit stream to link layer
  output rft_pkg::rft_word_t     txWord,
  input  wire logic              txReady,
  input  wire logic              txDone,
  input  wire logic              txError,
  // receive stream from link layer
  input  wire rft_pkg::rft_word_t rxWord,
  input  wire logic              rxGood,
  // status out
  output logic                   busyFlag
);
  ////////////////////////////////////////////////////////////////////////////////
  // registers
  rft_pkg::rft_shadow_t shadow_reg;
  logic [31:0]          aux_reg;
  logic [8:0]           timeLim_reg;
  logic [3:0]           port_reg;
  logic [1:0]           xfer_reg;
  rft_pkg::rft_state_t  state_reg;
  logic [2:0]           word_reg;
  logic                 cupd_reg;
  logic [31:0]          frame_reg [0:4];
  logic [31:0]          rx_reg [0:3];
  logic [2:0]           rxIdx_reg;
  logic                 rxKeep_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire wrEn   = psel && penable && pwrite;
  wire active = shadow_reg.status[rft_pkg::BIT_BUSY] ||
                shadow_reg.status[rft_pkg::BIT_DATA_REQ];
  wire cmdWr  = wrEn && paddr == rft_pkg::OFS_CMD;
  wire cmdOk  = cmdWr && (!active || pwdata[7:0] == rft_pkg::CMD_DEV_RESET);
  wire ctrlWr = wrEn && paddr == rft_pkg::OFS_CTRL;
  wire ctrlChg = ctrlWr && pwdata[7:0] != shadow_reg.control;
  wire softRstRise = ctrlWr && pwdata[rft_pkg::BIT_SOFT_RST] &&
                     !shadow_reg.control[rft_pkg::BIT_SOFT_RST];
  wire idle   = state_reg == rft_pkg::ST_IDLE;
  wire launch = idle && (cmdOk || ctrlChg);
  wire mapped = paddr <= rft_pkg::OFS_XFER && paddr[1:0] == 2'b00;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign busyFlag = shadow_reg.status[rft_pkg::BIT_BUSY];

  // read mux
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      rft_pkg::OFS_FEAT:   prdata = {16'h0000, shadow_reg.features};
      rft_pkg::OFS_COUNT:  prdata = {16'h0000, shadow_reg.count};
      rft_pkg::OFS_LBA_LO: prdata = {8'h00, shadow_reg.lba[23:0]};
      rft_pkg::OFS_LBA_HI: prdata = {8'h00, shadow_reg.lba[47:24]};
      rft_pkg::OFS_DEVICE: prdata = {24'h0000_00, shadow_reg.device};
      rft_pkg::OFS_CMD:    prdata = {24'h0000_00, shadow_reg.command};
      rft_pkg::OFS_CTRL:   prdata = {24'h0000_00, shadow_reg.control};
      rft_pkg::OFS_AUX:    prdata = aux_reg;
      rft_pkg::OFS_TLIM:   prdata = {23'h00_0000, timeLim_reg};
      rft_pkg::OFS_PORT:   prdata = {28'h000_0000, port_reg};
      rft_pkg::OFS_STATUS: prdata = {24'h0000_00, shadow_reg.status};
      rft_pkg::OFS_ERROR:  prdata = {24'h0000_00, shadow_reg.error};
      rft_pkg::OFS_XFER:   prdata = {30'h0000_0000, xfer_reg};
      default:             prdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // frame assembly from shadow contents at launch time
  wire        cmdFrame = cmdOk;
  wire [7:0]  cmdByte  = cmdOk ? pwdata[7:0] : shadow_reg.command;
  wire [7:0]  ctlByte  = ctrlChg ? pwdata[7:0] : shadow_reg.control;
  // command-update never paired with soft reset
  wire [7:0]  ctlSent  = cmdFrame ? (ctlByte & ~(8'h01 << rft_pkg::BIT_SOFT_RST)) : ctlByte;
  wire [7:0]  tlimByte = timeLim_reg[rft_pkg::BIT_TLIM_EN] ? timeLim_reg[7:0] : 8'h00;
  wire [31:0] w0 = {shadow_reg.features[7:0], cmdByte, cmdFrame, 3'b000, port_reg,
                    rft_pkg::TYPE_H2D};
  wire [31:0] w1 = {shadow_reg.device, shadow_reg.lba[23:0]};
  wire [31:0] w2 = {shadow_reg.features[15:8], shadow_reg.lba[47:24]};
  wire [31:0] w3 = {ctlSent, tlimByte, shadow_reg.count};

  // transmit word select
  assign txWord.valid = state_reg == rft_pkg::ST_SEND;
  assign txWord.last  = word_reg == rft_pkg::LAST_WORD;
  assign txWord.data  = frame_reg[word_reg];

  ////////////////////////////////////////////////////////////////////////////////
  // transmit sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= rft_pkg::ST_IDLE;
      word_reg  <= 3'h0;
      cupd_reg  <= 1'b0;
      for (int i = 0; i < 5; i++) frame_reg[i] <= 32'h0000_0000;
    end else begin
      case (state_reg)
        rft_pkg::ST_IDLE: if (launch) begin
          frame_reg[0] <= w0;
          frame_reg[1] <= w1;
          frame_reg[2] <= w2;
          frame_reg[3] <= w3;
          frame_reg[4] <= aux_reg;
          cupd_reg     <= cmdFrame;
          word_reg     <= 3'h0;
          state_reg    <= rft_pkg::ST_SEND;
        end
        rft_pkg::ST_SEND: if (txReady) begin
          if (txWord.last) state_reg <= rft_pkg::ST_WAIT;
          else word_reg <= word_reg + 3'h1;
        end
        rft_pkg::ST_WAIT: if (txDone || txError) state_reg <= rft_pkg::ST_IDLE;
        default: state_reg <= rft_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive capture; first four words stored whole, fifth word not kept, reserved bytes dropped at shadow load
  wire rxTake = rxWord.valid;
  wire rxHdr  = rxTake && rxIdx_reg == 3'h0;
  wire rxEnd  = rxTake && rxWord.last;
  wire rxOk   = rxEnd && rxKeep_reg && rxIdx_reg == rft_pkg::LAST_WORD && rxGood;
  wire rxApply = rxOk && active;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rxIdx_reg  <= 3'h0;
      rxKeep_reg <= 1'b0;
      for (int i = 0; i < 4; i++) rx_reg[i] <= 32'h0000_0000;
    end else if (rxTake) begin
      if (rxHdr) rxKeep_reg <= rxWord.data[7:0] == rft_pkg::TYPE_D2H;
      if (rxIdx_reg < rft_pkg::LAST_WORD) rx_reg[rxIdx_reg[1:0]] <= rxWord.data;
      rxIdx_reg <= rxEnd ? 3'h0 : rxIdx_reg + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shadow block: software writes, busy set, received frame load
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      shadow_reg <= '0;
      aux_reg    <= 32'h0000_0000;
      timeLim_reg <= 9'h000;
      port_reg   <= 4'h0;
      xfer_reg   <= 2'b00;
    end else begin
      if (wrEn && paddr == rft_pkg::OFS_FEAT)   shadow_reg.features <= pwdata[15:0];
      if (wrEn && paddr == rft_pkg::OFS_COUNT)  shadow_reg.count <= pwdata[15:0];
      if (wrEn && paddr == rft_pkg::OFS_LBA_LO) shadow_reg.lba[23:0] <= pwdata[23:0];
      if (wrEn && paddr == rft_pkg::OFS_LBA_HI) shadow_reg.lba[47:24] <= pwdata[23:0];
      if (wrEn && paddr == rft_pkg::OFS_DEVICE) shadow_reg.device <= pwdata[7:0];
      if (wrEn && paddr == rft_pkg::OFS_AUX)    aux_reg <= pwdata;
      if (wrEn && paddr == rft_pkg::OFS_TLIM)   timeLim_reg <= pwdata[8:0];
      if (wrEn && paddr == rft_pkg::OFS_PORT)   port_reg <= pwdata[3:0];
      if (cmdOk && idle) shadow_reg.command <= pwdata[7:0];
      if (ctrlWr) shadow_reg.control <= pwdata[7:0];
      // received values copied; reserved bytes dropped
      if (rxApply) begin
        shadow_reg.status <= rx_reg[0][23:16];
        shadow_reg.error  <= rx_reg[0][31:24];
        shadow_reg.device <= rx_reg[1][31:24];
        shadow_reg.lba    <= {rx_reg[2][23:0], rx_reg[1][23:0]};
        shadow_reg.count  <= rx_reg[3][15:0];
      end
      // busy set wins over a received frame in the same cycle
      if ((cmdOk && idle) || softRstRise)
        shadow_reg.status[rft_pkg::BIT_BUSY] <= 1'b1;
      // outcome of the last frame sent: bit0 finished (done or error), bit1 error
      if (state_reg == rft_pkg::ST_WAIT && (txDone || txError))
        xfer_reg <= {txError, 1'b1};
      else if (launch)
        xfer_reg <= 2'b00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_cmd_taken;
    cmdOk && idle;
  endsequence

  a_busy_after_cmd: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_cmd_taken |=> busyFlag)
    else $error("busy not set after command write");

  a_frame_header: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (txWord.valid && word_reg == 3'h0) |-> txWord.data[7:0] == 8'h27)
    else $error("wrong frame type");

  a_no_cupd_soft_reset_bit: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (txWord.valid && word_reg == 3'h3 && cupd_reg) |-> !txWord.data[26])
    else $error("command-update sent with soft reset");

  a_cupd_source: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (txWord.valid && word_reg == 3'h0) |-> txWord.data[15] == cupd_reg)
    else $error("command-update bit mismatch");

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (txWord.valid && word_reg == 3'h0) |-> txWord.data[14:12] == 3'b000)
    else $error("reserved bits not zero");

  a_ctrl_no_busy: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (ctrlWr && !softRstRise && !cmdWr && !busyFlag && !rxApply) |=> !busyFlag)
    else $error("busy raised by control write");

  a_launch_send: assert property (@(posedge ref_clk) disable iff (sys_rst)
    launch |=> txWord.valid && word_reg == 3'h0)
    else $error("frame not started");

  a_discard_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rxOk && !active && !cmdOk && !softRstRise && !ctrlWr) |=> $stable(shadow_reg.status))
    else $error("frame applied while idle");

  a_busy_cmd_drop: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cmdWr && active && pwdata[7:0] != 8'h08) |-> !launch)
    else $error("command accepted while busy");
endmodule
`default_nettype wire

/* bench/rft_drive_model.sv */
`timescale 1ns/1ns
`default_nettype none
//////////////////////////////////////////////////////////////////////
// drive-side transport seen through the link layer
module rft_drive_model (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  // link side
  input  wire rft_pkg::rft_word_t txWord,
  output logic                    txReady,
  output logic                    txDone,
  output logic                    txError,
  output rft_pkg::rft_word_t      rxWord,
  output logic                    rxGood,
  // bench control
  input  wire logic               slow,
  input  wire logic               failNext,
  input  wire logic               sendGo,
  input  wire logic [159:0]       sendFrame,
  output logic      [159:0]       gotFrame,
  output logic      [7:0]         gotCnt,
  output logic      [2:0]         gotLen
);
  logic [2:0] txIdx;
  logic [2:0] rxIdx;
  logic       rxBusy;
  logic       slowTick;
  logic       rxEnd;
  // slow mode stalls every other cycle
  assign txReady = !slow || slowTick;
  assign rxEnd   = rxIdx == rft_pkg::LAST_WORD;
  //////////////////////////////////////////////////////////////////////
  // local copy updated word by word, outcome pulsed after the last
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      txIdx    <= 3'h0;
      slowTick <= 1'b0;
      txDone   <= 1'b0;
      txError  <= 1'b0;
      gotCnt   <= 8'h00;
      gotLen   <= 3'h0;
      gotFrame <= '0;
    end else begin
      slowTick <= !slowTick;
      txDone   <= 1'b0;
      txError  <= 1'b0;
      if (txWord.valid && txReady) begin
        gotFrame[txIdx*32 +: 32] <= txWord.data;
        txIdx <= txWord.last ? 3'h0 : txIdx + 3'h1;
        if (txWord.last) begin
          gotLen  <= txIdx + 3'h1;
          gotCnt  <= gotCnt + 8'h01;
          txDone  <= !failNext;
          txError <= failNext;
        end
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // five-word frame out; the released data line wiggles every cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rxBusy <= 1'b0;
      rxIdx  <= 3'h0;
      rxWord <= '0;
      rxGood <= 1'b0;
    end else begin
      rxGood       <= 1'b0;
      rxWord.valid <= 1'b0;
      rxWord.last  <= 1'b0;
      rxWord.data  <= ~rxWord.data;
      if (sendGo || rxBusy) begin
        rxWord.valid <= 1'b1;
        rxWord.data  <= sendFrame[rxIdx*32 +: 32];
        rxWord.last  <= rxEnd;
        rxGood       <= rxEnd;
        rxBusy       <= !rxEnd;
        rxIdx        <= rxEnd ? 3'h0 : rxIdx + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  rft_pkg::rft_word_t txWord, rxWord;
  logic txReady, txDone, txError, rxGood, busyFlag;
  logic slow, failNext, sendGo, errSeen;
  logic [159:0] sendFrame, gotFrame, expF;
  logic [7:0] gotCnt;
  logic [2:0] gotLen;
  int num_errors, checks, cyc;
  //////////////////////////////////////////////////////////////////////
  rft_register_fis_transport dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txWord(txWord), .txReady(txReady), .txDone(txDone), .txError(txError),
    .rxWord(rxWord), .rxGood(rxGood), .busyFlag(busyFlag));
  rft_drive_model drv_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .txWord(txWord), .txReady(txReady), .txDone(txDone), .txError(txError),
    .rxWord(rxWord), .rxGood(rxGood), .slow(slow), .failNext(failNext),
    .sendGo(sendGo), .sendFrame(sendFrame), .gotFrame(gotFrame),
    .gotCnt(gotCnt), .gotLen(gotLen));
  //////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #25 ref_clk = !ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////////
  // apb transfer: setup, then access until pready
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    chk(q & m, e);
  endtask
  // wait for n frames at the drive, bounded
  task automatic waitFrames(input logic [7:0] n);
    int k;
    for (k = 0; k < 200 && gotCnt !== n; k++) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    chk({24'h0, gotCnt}, {24'h0, n});
  endtask
  task automatic sendD2h(input logic [159:0] f);
    sendFrame <= f;
    sendGo <= 1'b1;
    @(posedge ref_clk);
    sendGo <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {ref_clk, psel, penable, pwrite, paddr, pwdata, sendGo, failNext} = '0;
    {sendFrame, num_errors, checks, cyc} = '0;
    sys_rst = 1'b1;
    slow = 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdChk(rft_pkg::OFS_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
    rdChk(rft_pkg::OFS_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    rdChk(8'h34, 32'h0000_0000, 32'h0000_0000);
    chk({31'h0, errSeen}, 32'h1);
    wr(rft_pkg::OFS_FEAT, 32'h0000_A1B2);
    wr(rft_pkg::OFS_COUNT, 32'h0000_0304);
    wr(rft_pkg::OFS_LBA_LO, 32'h0011_2233);
    wr(rft_pkg::OFS_LBA_HI, 32'h0044_5566);
    wr(rft_pkg::OFS_DEVICE, 32'h0000_0040);
    wr(rft_pkg::OFS_AUX, 32'hDEAD_BEEF);
    wr(rft_pkg::OFS_TLIM, 32'h0000_0155);
    wr(rft_pkg::OFS_PORT, 32'h0000_0005);
    wr(rft_pkg::OFS_CMD, 32'h0000_0025);
    repeat (rft_pkg::BUSY_LIMIT_CYC - 1) @(posedge ref_clk);
    chk({31'h0, busyFlag}, 32'h1);
    waitFrames(8'h01);
    expF = {32'hDEAD_BEEF, 32'h0055_0304, 32'hA144_5566, 32'h4011_2233, 32'hB225_8527};
    for (int i = 0; i < 5; i++) chk(gotFrame[i*32 +: 32], expF[i*32 +: 32]);
    chk({29'h0, gotLen}, 32'h5);
    rdChk(rft_pkg::OFS_XFER, 32'h0000_0001, 32'h0000_0003);
    wr(rft_pkg::OFS_CMD, 32'h0000_0030);
    waitFrames(8'h01);
    wr(rft_pkg::OFS_CMD, {24'h0, rft_pkg::CMD_DEV_RESET});
    waitFrames(8'h02);
    chk(gotFrame[31:0], 32'hB208_8527);
    sendD2h({32'h0, 32'h0000_0A0B, 32'h0066_5544, 32'hE099_8877, 32'h0450_4034});
    rdChk(rft_pkg::OFS_STATUS, 32'h0000_0050, 32'hFFFF_FFFF);
    rdChk(rft_pkg::OFS_ERROR, 32'h0000_0004, 32'hFFFF_FFFF);
    rdChk(rft_pkg::OFS_COUNT, 32'h0000_0A0B, 32'h0000_FFFF);
    rdChk(rft_pkg::OFS_LBA_LO, 32'h0099_8877, 32'h00FF_FFFF);
    rdChk(rft_pkg::OFS_LBA_HI, 32'h0066_5544, 32'h00FF_FFFF);
    rdChk(rft_pkg::OFS_DEVICE, 32'h0000_00E0, 32'h0000_00FF);
    chk({31'h0, busyFlag}, 32'h0);
    sendD2h({32'h0, 32'h0000_1111, 32'h0066_5544, 32'hE099_8877, 32'h0451_4034});
    rdChk(rft_pkg::OFS_STATUS, 32'h0000_0050, 32'hFFFF_FFFF);
    rdChk(rft_pkg::OFS_COUNT, 32'h0000_0A0B, 32'h0000_FFFF);
    wr(rft_pkg::OFS_TLIM, 32'h0000_0077);
    wr(rft_pkg::OFS_CTRL, 32'h0000_0002);
    waitFrames(8'h03);
    chk({16'h0, gotFrame[15:0]}, 32'h0527);
    chk(gotFrame[127:96], 32'h0200_0A0B);
    chk({31'h0, busyFlag}, 32'h0);
    wr(rft_pkg::OFS_CTRL, 32'h0000_0002);
    waitFrames(8'h03);
    failNext <= 1'b1;
    wr(rft_pkg::OFS_CTRL, 32'h0000_0006);
    repeat (rft_pkg::BUSY_LIMIT_CYC - 1) @(posedge ref_clk);
    chk({31'h0, busyFlag}, 32'h1);
    waitFrames(8'h04);
    chk({16'h0, gotFrame[15:0]}, 32'h0527);
    chk({24'h0, gotFrame[127:120]}, 32'h06);
    rdChk(rft_pkg::OFS_XFER, 32'h0000_0002, 32'h0000_0002);
    tally_and_finish();
  end
endmodule
`default_nettype wire
